// File: shared/cvpc_params.svh
// Offsets, field positions, reset values and timing counts for the comparator/reference port block.
`ifndef CVPC_PARAMS_SVH
`define CVPC_PARAMS_SVH
// Register indices; the byte address on APB is four times the index.
`define CVPC_IDX_PORT_DATA 8'h05
`define CVPC_IDX_DIR 8'h85
`define CVPC_IDX_CMP_CTRL 8'h1F
`define CVPC_IDX_REF_CTRL 8'h9F
// Reset values.
`define CVPC_RST_DIR 8'h1F
`define CVPC_RST_CMP_CTRL 8'h00
`define CVPC_RST_REF_CTRL 8'h00
`define CVPC_RST_PORT_LATCH 5'h00
// Field positions.
`define CVPC_REF_EN_BIT 7
`define CVPC_REF_OE_BIT 6
`define CVPC_REF_RANGE_BIT 5
`define CVPC_CMP_C2_BIT 7
`define CVPC_CMP_C1_BIT 6
`define CVPC_CMP_CIS_BIT 3
// Writable masks; unimplemented bits read as zero.
`define CVPC_MASK_REF_CTRL 8'hEF
`define CVPC_MASK_CMP_WR 8'h0F
`define CVPC_MASK_DIR 8'h1F
// Comparator mode codes.
`define CVPC_MODE_PIN_OUT 3'h6
`define CVPC_MODE_OFF 3'h7
// System clocks in one instruction cycle.
`define CVPC_CYCLE_CLKS 4
`endif

// File: shared/cvpc_pkg.sv
// Types shared by the comparator/reference port block.
package cvpc_pkg;
   // Reference control register layout.
   typedef struct packed {
      logic enable;
      logic pin_oe;
      logic range_sel;
      logic unused;
      logic [3:0] level;
   } cvpc_ref_ctrl_s;
   // Comparator control register layout.
   typedef struct packed {
      logic c2_result;
      logic c1_result;
      logic [1:0] unused;
      logic input_switch;
      logic [2:0] mode;
   } cvpc_cmp_ctrl_s;
   // Instruction cycle phase.
   typedef logic [1:0] cvpc_phase_t;
endpackage

// File: logic/cvpc_sync2.sv
// Two-flop synchroniser for asynchronous levels.
`timescale 1ns/1ps
module cvpc_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   // The first stage feeds only the second, so metastability never reaches logic.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // cvpc_sync2

// File: logic/cvpc_top.sv
// Port, comparator control and voltage reference control with an APB register slave.
//
// What this block does
// - Port latch updates at instruction-cycle end; pins sampled at cycle start.
// - Comparator result bits are readable and ignore writes.
// - Mode 110 routes raw comparator outputs onto port pins 3 and 4.
// - Direction bits still gate pin 3 and 4 drivers in that mode.
// - Port reads return zero for analog-configured pins.
// - Wake from sleep leaves the reference control register unchanged.
// - Reset clears reference enable, pin enable, range and level bits.
// - Reference reaches pin 2 only when its direction bit and pin enable are set.
// - Reference controls and comparator mode are independent of each other.
// - Reference register resets to zero, comparator register to zero; unused bits read zero.
// - Set direction bit floats the pin; cleared bit drives the latch, pin 4 only its low level (open drain).
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "cvpc_params.svh"
module cvpc_top #(
   parameter int CYCLE_CLKS = `CVPC_CYCLE_CLKS
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic NRST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Port pins
   input wire logic [4:0] PORT_IN,
   output logic [4:0] PORT_OUT,
   output logic [4:0] PORT_OE,
   // Analog comparator results, asynchronous
   input wire logic CMP1_OUT,
   input wire logic CMP2_OUT,
   // Sleep wake indication, no effect on reference control
   input wire logic SLEEP_WAKE,
   // Analog controls
   output logic REF_ENABLE,
   output logic REF_RANGE_SEL,
   output logic [3:0] REF_LEVEL,
   output logic REF_PIN_CONNECT,
   output logic [2:0] CMP_MODE,
   output logic CMP_INPUT_SWITCH
);
   cvpc_pkg::cvpc_ref_ctrl_s ref_reg;
   cvpc_pkg::cvpc_cmp_ctrl_s cmp_reg;
   logic [4:0] dir_reg;
   logic [4:0] latch_reg;
   logic [4:0] pend_reg;
   logic pend_valid_reg;
   logic [4:0] sample_reg;
   cvpc_pkg::cvpc_phase_t phase_reg;
   logic [31:0] rdata_reg;
   logic err_reg;
   logic [4:0] pin_sync;
   logic [1:0] cmp_sync;
   logic cycle_start;
   logic cycle_end;
   logic setup;
   logic [7:0] idx;
   logic wr_port;
   logic [4:0] analog_mask;
   logic [4:0] drive_val;

   // Pins which the comparator mode dedicates to analog inputs.
   function automatic logic [4:0] analog_pins(input logic [2:0] mode);
      if (mode == `CVPC_MODE_OFF) begin
         analog_pins = 5'h00;
      end else if (mode == `CVPC_MODE_PIN_OUT) begin
         analog_pins = 5'h07;
      end else begin
         analog_pins = 5'h0F;
      end
   endfunction

   // True when the address word index hits a mapped register.
   function automatic logic mapped(input logic [7:0] i);
      mapped = (i == `CVPC_IDX_PORT_DATA) || (i == `CVPC_IDX_DIR) ||
         (i == `CVPC_IDX_CMP_CTRL) || (i == `CVPC_IDX_REF_CTRL);
   endfunction

   // Pins and comparator results come from outside the clock domain.
   cvpc_sync2 #(.WIDTH(5)) u_pin_sync (
      .clk(CLK_SYS),
      .nrst(NRST),
      .d(PORT_IN),
      .q(pin_sync)
   );
   cvpc_sync2 #(.WIDTH(2)) u_cmp_sync (
      .clk(CLK_SYS),
      .nrst(NRST),
      .d({CMP2_OUT, CMP1_OUT}),
      .q(cmp_sync)
   );

   // Instruction-cycle divider; phase 0 opens a cycle and the last phase closes it.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         phase_reg <= 2'h0;
      end else if (phase_reg == 2'(CYCLE_CLKS - 1)) begin
         phase_reg <= 2'h0;
      end else begin
         phase_reg <= phase_reg + 2'h1;
      end
   end
   assign cycle_start = (phase_reg == 2'h0);
   assign cycle_end = (phase_reg == 2'(CYCLE_CLKS - 1));

   // Bus decode.
   assign setup = PSEL && !PENABLE;
   assign idx = PADDR[9:2];
   assign wr_port = PSEL && PENABLE && PWRITE && (idx == `CVPC_IDX_PORT_DATA);
   assign analog_mask = analog_pins(cmp_reg.mode);

   // Pins are sampled only when an instruction cycle opens.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         sample_reg <= 5'h00;
      end else if (cycle_start) begin
         sample_reg <= pin_sync;
      end
   end

   // A port write is held and lands in the latch when the cycle closes.
   // A write arriving on the closing edge itself waits for the next close.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         pend_reg <= 5'h00;
         pend_valid_reg <= 1'b0;
         latch_reg <= `CVPC_RST_PORT_LATCH;
      end else begin
         if (cycle_end && pend_valid_reg) begin
            latch_reg <= pend_reg;
         end
         if (wr_port) begin
            pend_reg <= PWDATA[4:0];
            pend_valid_reg <= 1'b1;
         end else if (cycle_end) begin
            pend_valid_reg <= 1'b0;
         end
      end
   end

   // Direction register.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         dir_reg <= 5'(`CVPC_RST_DIR);
      end else if (PSEL && PENABLE && PWRITE && (idx == `CVPC_IDX_DIR)) begin
         dir_reg <= PWDATA[4:0];
      end
   end

   // Reference control; only reset or a bus write alters it, never a wake.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         ref_reg <= `CVPC_RST_REF_CTRL;
      end else if (PSEL && PENABLE && PWRITE && (idx == `CVPC_IDX_REF_CTRL)) begin
         ref_reg <= PWDATA[7:0] & `CVPC_MASK_REF_CTRL;
      end
   end

   // Comparator control writable bits; results track the synchronised comparators.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         cmp_reg <= `CVPC_RST_CMP_CTRL;
      end else begin
         cmp_reg.c2_result <= cmp_sync[1];
         cmp_reg.c1_result <= cmp_sync[0];
         if (PSEL && PENABLE && PWRITE && (idx == `CVPC_IDX_CMP_CTRL)) begin
            cmp_reg.input_switch <= PWDATA[`CVPC_CMP_CIS_BIT];
            cmp_reg.mode <= PWDATA[2:0];
         end
      end
   end

   // Read data is captured in the setup cycle so it comes from flip-flops.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         rdata_reg <= 32'h0000_0000;
         err_reg <= 1'b0;
      end else if (setup) begin
         err_reg <= !mapped(idx);
         rdata_reg <= 32'h0000_0000;
         if (!PWRITE) begin
            unique case (idx)
               `CVPC_IDX_PORT_DATA: rdata_reg <= {27'h0, sample_reg & ~analog_mask};
               `CVPC_IDX_DIR: rdata_reg <= {27'h0, dir_reg};
               `CVPC_IDX_CMP_CTRL: rdata_reg <= {24'h0, cmp_reg & 8'hCF};
               `CVPC_IDX_REF_CTRL: rdata_reg <= {24'h0, ref_reg & `CVPC_MASK_REF_CTRL};
               default: rdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign PRDATA = rdata_reg;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && err_reg;

   // Output path: pins 3 and 4 carry raw comparator levels in pin-output mode.
   // This path is deliberately left unsynchronised, so it may glitch.
   always_comb begin
      drive_val = latch_reg;
      if (cmp_reg.mode == `CVPC_MODE_PIN_OUT) begin
         drive_val[3] = CMP1_OUT;
         drive_val[4] = CMP2_OUT;
      end
   end

   // Driver enables follow the direction bits in every mode; pin 4 is open drain.
   always_comb begin
      PORT_OUT = drive_val;
      PORT_OE = ~dir_reg;
      PORT_OUT[4] = 1'b0;
      PORT_OE[4] = !dir_reg[4] && !drive_val[4];
   end

   // Analog controls; the reference pin switch needs both conditions.
   assign REF_ENABLE = ref_reg.enable;
   assign REF_RANGE_SEL = ref_reg.range_sel;
   assign REF_LEVEL = ref_reg.level;
   assign REF_PIN_CONNECT = dir_reg[2] && ref_reg.pin_oe;
   assign CMP_MODE = cmp_reg.mode;
   assign CMP_INPUT_SWITCH = cmp_reg.input_switch;

   // The wake indication is accepted but intentionally changes nothing.
   logic wake_unused;
   assign wake_unused = SLEEP_WAKE;
endmodule // cvpc_top

// File: sim/cvpc_analog_model.sv
// Far-side model of the pads and the two analog comparators.
`timescale 1ns/1ps
module cvpc_analog_model (
   // Device pad drivers
   input wire logic [4:0] pad_out,
   input wire logic [4:0] pad_oe,
   // Outside sources set by the bench
   input wire logic [4:0] ext_lvl,
   input wire logic c1_lvl,
   input wire logic c2_lvl,
   // Levels seen by the device
   output logic [4:0] pad_lvl,
   output logic cmp1,
   output logic cmp2
);
   // A driven pad shows the device value, a floating one the outside source.
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         pad_lvl[i] = pad_oe[i] ? pad_out[i] : ext_lvl[i];
      end
   end
   // Comparators answer at once, so the raw pin path is seen undelayed.
   assign cmp1 = c1_lvl;
   assign cmp2 = c2_lvl;
endmodule // cvpc_analog_model

// File: sim/cvpc_top_chk.sv
// Concurrent checks on the ports of the comparator and reference port block.
`timescale 1ns/1ps
`include "cvpc_params.svh"
module cvpc_top_chk #(
   parameter int CYCLE_CLKS = 4
) (
   // Clock, reset and bus
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Pins and analog controls
   input wire logic [4:0] PORT_OUT,
   input wire logic [4:0] PORT_OE,
   input wire logic CMP1_OUT,
   input wire logic REF_ENABLE,
   input wire logic [3:0] REF_LEVEL,
   input wire logic REF_PIN_CONNECT,
   input wire logic [2:0] CMP_MODE
);
   // Access-phase decode; setup cycles carry no effect of their own.
   wire logic acc = PSEL && PENABLE;
   wire logic wr = acc && PWRITE;
   wire logic [7:0] idx = PADDR[9:2];
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   ready_const_a: assert property (acc |-> PREADY) else $error("bus wait seen");
   rst_clear_a: assert property ($rose(NRST) |-> !REF_ENABLE && REF_LEVEL == 4'h0
      && !REF_PIN_CONNECT && CMP_MODE == 3'h0 && PORT_OE == 5'h00) else $error("reset state");
   map_err_a: assert property (acc |-> PSLVERR == !(idx inside {`CVPC_IDX_PORT_DATA,
      `CVPC_IDX_DIR, `CVPC_IDX_CMP_CTRL, `CVPC_IDX_REF_CTRL})) else $error("error flag");
   dir_oe_a: assert property (wr && idx == `CVPC_IDX_DIR
      |=> PORT_OE[3:0] == ~$past(PWDATA[3:0])) else $error("direction drive");
   mode_wr_a: assert property (wr && idx == `CVPC_IDX_CMP_CTRL
      |=> CMP_MODE == $past(PWDATA[2:0])) else $error("mode write");
   ref_hold_a: assert property (!(wr && idx == `CVPC_IDX_REF_CTRL)
      |=> $stable({REF_ENABLE, REF_LEVEL})) else $error("reference changed");
   ref_pin_a: assert property (REF_PIN_CONNECT |-> !PORT_OE[2])
      else $error("ref on driven pin");
   pin3_mux_a: assert property (CMP_MODE == `CVPC_MODE_PIN_OUT
      |-> PORT_OUT[3] == CMP1_OUT) else $error("pin 3 routing");
endmodule // cvpc_top_chk

// File: sim/tb_cvpc_top.sv
// Self-checking bench for the comparator and reference port block.
`timescale 1ns/1ps
`include "cvpc_params.svh"
module tb_cvpc_top;
   // Byte address is four times the register index.
   localparam logic [11:0] A_PORT = {2'h0, `CVPC_IDX_PORT_DATA, 2'h0};
   localparam logic [11:0] A_DIR = {2'h0, `CVPC_IDX_DIR, 2'h0};
   localparam logic [11:0] A_CMP = {2'h0, `CVPC_IDX_CMP_CTRL, 2'h0};
   localparam logic [11:0] A_REF = {2'h0, `CVPC_IDX_REF_CTRL, 2'h0};
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic wake = 1'b0, c1 = 1'b0, c2 = 1'b0, pready, perr, er, ren, rrng, rcon, csw, cm1, cm2;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] rlvl;
   logic [2:0] cmode;
   logic [4:0] p_in, p_out, p_oe, ext = 5'h1F;
   int error_cnt = 0, total_checks = 0, cyc = 0;
   // Clock at 200 MHz.
   always #2.5 clk = ~clk;
   cvpc_top u_dut (.CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr),
      .PORT_IN(p_in), .PORT_OUT(p_out), .PORT_OE(p_oe), .CMP1_OUT(cm1), .CMP2_OUT(cm2),
      .SLEEP_WAKE(wake), .REF_ENABLE(ren), .REF_RANGE_SEL(rrng), .REF_LEVEL(rlvl),
      .REF_PIN_CONNECT(rcon), .CMP_MODE(cmode), .CMP_INPUT_SWITCH(csw));
   cvpc_analog_model u_far (.pad_out(p_out), .pad_oe(p_oe), .ext_lvl(ext), .c1_lvl(c1),
      .c2_lvl(c2), .pad_lvl(p_in), .cmp1(cm1), .cmp2(cm2));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer; request held until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic t_reset();
      apb(1'b0, A_DIR, 32'h0);
      chk(rd, 32'h1F);
      apb(1'b0, A_CMP, 32'h0);
      chk(rd, 32'h00);
      apb(1'b0, A_REF, 32'h0);
      chk(rd, 32'h00);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, er}, 32'h1);
   endtask
   task automatic t_ref();
      apb(1'b1, A_REF, 32'hFF);
      apb(1'b0, A_REF, 32'h0);
      chk(rd, 32'hEF);
      chk({25'h0, ren, rrng, rlvl, rcon}, 32'h7F);
      apb(1'b1, A_CMP, 32'h06);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      apb(1'b0, A_REF, 32'h0);
      chk(rd, 32'hEF);
      apb(1'b1, A_DIR, 32'h1B);
      @(posedge clk);
      chk({31'h0, rcon}, 32'h0);
   endtask
   // Result bits refuse writes; with pins 3 and 4 enabled they carry the raw comparators.
   task automatic t_cmp();
      apb(1'b1, A_CMP, 32'hCE);
      apb(1'b0, A_CMP, 32'h0);
      chk(rd, 32'h0E);
      chk({31'h0, csw}, 32'h1);
      c1 <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, A_CMP, 32'h0);
      chk(rd, 32'h4E);
      apb(1'b1, A_DIR, 32'h03);
      @(posedge clk);
      chk({30'h0, p_out[3], p_oe[3]}, 32'h3);
      chk({30'h0, p_out[4], p_oe[4]}, 32'h1);
      apb(1'b1, A_DIR, 32'h1F);
      @(posedge clk);
      chk({27'h0, p_oe}, 32'h0);
      c1 <= 1'b0;
   endtask
   task automatic t_port();
      logic [2:0] md [3] = '{3'h7, 3'h6, 3'h2};
      logic [4:0] ex [3] = '{5'h1F, 5'h18, 5'h10};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, A_CMP, {29'h0, md[i]});
         repeat (8) @(posedge clk);
         apb(1'b0, A_PORT, 32'h0);
         chk(rd, {27'h0, ex[i]});
      end
      // All pins digital, so the driven latch value is read back from the pads.
      apb(1'b1, A_CMP, 32'h07);
      apb(1'b1, A_DIR, 32'h10);
      apb(1'b1, A_PORT, 32'h0A);
      repeat (5) @(posedge clk);
      chk({28'h0, p_out[3:0]}, 32'hA);
      repeat (8) @(posedge clk);
      apb(1'b0, A_PORT, 32'h0);
      chk(rd, 32'h1A);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // A hang is cut short by a cycle ceiling.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_ref();
      t_cmp();
      t_port();
      nrst <= 1'b0;
      @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      summarize();
   end
endmodule // tb_cvpc_top
bind cvpc_top cvpc_top_chk #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE),
   .CMP1_OUT(CMP1_OUT), .REF_ENABLE(REF_ENABLE), .REF_LEVEL(REF_LEVEL),
   .REF_PIN_CONNECT(REF_PIN_CONNECT), .CMP_MODE(CMP_MODE));
